// File: afs_handshake.sv
// Auxiliary M, S and T code handshake towards the ladder-logic PLC.
// Assumes block commands and motion status come from logic on clk_i;
// the completion and lock inputs are pins and are synchronised here.
`timescale 1ns/1ns

// Overview of operation
// - Accept M value up to eight digits, output binary code with strobe.
// - With multi-M enabled, output up to three M codes on separate groups.
// - Digit count above configured limit raises alarm, nothing is output.
// - M and T strobes rise a configured delay, typically 64 ms, after their code appears.
// - Primary M code is 32 bits, held steady during the handshake.
// - Strobes drop after completion held high longer than acceptance time.
// - Completion low clears every code output to zero.
// - Next block waits until motion of current block also completes.
// - I/O spindle mode accepts S1 to S8, one bit each, else alarm.
// - Auxiliary functions run concurrently with other block commands.
// - Spindle code bit and spindle strobe rise together; PLC holds completion low.
// - Analog spindle mode drives four gear bits from per-gear maximum speeds.
// - S command updates internal spindle speed even under lock.
// - T value goes to tool data output, then tool strobe rises.
// - With M, S, T together, next block only after completion seen high.
// - Subprogram and macro call M codes execute without outputs.
// - Lock in auto or MDI suppresses outputs except stop and end M codes.
module afs_handshake
    import afs_pkg::*;
#(
    parameter int unsigned STROBE_DELAY = STROBE_DELAY_CYC,
    parameter int unsigned ACCEPT_TIME  = ACCEPT_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Block executor side
    input  wire logic        cmd_valid_i,
    input  wire afs_cmd_t    cmd_i,
    input  wire logic        motion_done_i,
    output logic             cmd_ready_o,
    output logic             block_done_o,
    output logic             alarm_o,
    // Configuration
    input  wire afs_limits_t limits_i,
    input  wire logic        multi_m_per_block_enable_i,
    input  wire logic        io_spindle_mode_i,
    input  wire logic        auto_mode_i,
    input  wire logic [127:0] gear_max_i,
    // PLC pins
    input  wire logic        shared_completion_input_i,
    input  wire logic        aux_lock_input_i,
    output logic [M_W-1:0]   m_code_o,
    output logic [MX_W-1:0]  m2_code_o,
    output logic [MX_W-1:0]  m3_code_o,
    output logic [31:0]      s_code_o,
    output logic [3:0]       gear_o,
    output logic [31:0]      tool_data_o,
    output logic             m_code_strobe_o,
    output logic             second_m_code_strobe_o,
    output logic             third_m_code_strobe_o,
    output logic             spindle_code_strobe_o,
    output logic             tool_code_strobe_o,
    output logic             distribution_end_flag_o,
    output logic [31:0]      spindle_speed_o
);

    function automatic logic too_long(input logic [31:0] v, input logic [3:0] d);
        logic [31:0] lim;
        lim = 32'h0000_0000;
        case (d)
            4'h1:    lim = 32'h0000_000A;
            4'h2:    lim = 32'h0000_0064;
            4'h3:    lim = 32'h0000_03E8;
            4'h4:    lim = 32'h0000_2710;
            4'h5:    lim = 32'h0001_86A0;
            4'h6:    lim = 32'h000F_4240;
            4'h7:    lim = 32'h0098_9680;
            default: lim = 32'h05F5_E100;
        endcase
        too_long = (d == 4'h0) || (v >= lim);
    endfunction : too_long

    function automatic logic lock_exempt(input logic [31:0] v);
        lock_exempt = (v == M_STOP) || (v == M_OPT_STOP) || (v == M_END) || (v == M_END_RWD);
    endfunction : lock_exempt

    // Pin synchronisers
    logic [1:0] fin_sync_r;
    logic [1:0] lock_sync_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fin_sync_r  <= 2'h0;
            lock_sync_r <= 2'h0;
        end else begin
            fin_sync_r  <= {fin_sync_r[0], shared_completion_input_i};
            lock_sync_r <= {lock_sync_r[0], aux_lock_input_i};
        end
    end
    wire logic fin_s  = fin_sync_r[1];
    wire logic lock_s = lock_sync_r[1] && auto_mode_i;

    // Command decode
    wire logic [31:0] s_v     = cmd_i.s_val;
    wire logic        m_en2   = multi_m_per_block_enable_i && (cmd_i.m_cnt >= 2'h2);
    wire logic        m_en3   = multi_m_per_block_enable_i && (cmd_i.m_cnt == 2'h3);
    wire logic        bad_m   = (cmd_i.m_cnt != 2'h0) && (too_long(cmd_i.m_val, limits_i.m_digits)
                                || (m_en2 && too_long({16'h0000, cmd_i.m2_val}, limits_i.m_digits))
                                || (m_en3 && too_long({16'h0000, cmd_i.m3_val}, limits_i.m_digits)));
    wire logic        bad_s   = cmd_i.s_valid && (too_long(s_v, limits_i.s_digits)
                                || (io_spindle_mode_i && ((s_v < S_IO_MIN) || (s_v > S_IO_MAX))));
    wire logic        bad_t   = cmd_i.t_valid && too_long(cmd_i.t_val, limits_i.t_digits);
    wire logic        bad     = bad_m || bad_s || bad_t;
    // Lock gates each group; internal codes gate the three M groups only
    wire logic        out_m1  = (cmd_i.m_cnt != 2'h0) && !cmd_i.m_internal[0]
                                && (!lock_s || lock_exempt(cmd_i.m_val));
    wire logic        out_m2  = m_en2 && !cmd_i.m_internal[1]
                                && (!lock_s || lock_exempt({16'h0000, cmd_i.m2_val}));
    wire logic        out_m3  = m_en3 && !cmd_i.m_internal[2]
                                && (!lock_s || lock_exempt({16'h0000, cmd_i.m3_val}));
    wire logic        out_s   = cmd_i.s_valid && !lock_s;
    wire logic        out_t   = cmd_i.t_valid && !lock_s;
    wire logic        any_out = out_m1 || out_m2 || out_m3 || out_s || out_t;
    wire logic [2:0]  s_idx   = 3'(s_v - S_IO_MIN);
    wire logic [31:0] s_word  = io_spindle_mode_i ? {24'h000000, 8'(8'h01 << s_idx)} : s_v;
    wire logic [3:0]  gear    = (s_v <= gear_max_i[31:0])  ? 4'h1 :
                                (s_v <= gear_max_i[63:32]) ? 4'h2 :
                                (s_v <= gear_max_i[95:64]) ? 4'h4 : 4'h8;
    wire logic        take    = cmd_valid_i && cmd_ready_o;

    afs_state_t  state_r;
    afs_state_t  state_nxt;
    logic [31:0] dly_r;
    logic [31:0] acc_r;
    logic [4:0]  sel_r;
    logic [31:0] s_hold_r;
    logic [31:0] t_hold_r;
    logic [3:0]  gear_hold_r;

    wire logic dly_done = (dly_r == 32'h0000_0000);
    wire logic acc_done = fin_s && (acc_r == 32'h0000_0000);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:   if (take && !bad) state_nxt = any_out ? ST_DELAY : ST_MOTION;
            ST_DELAY:  if (dly_done) state_nxt = ST_STROBE;
            ST_STROBE: if (acc_done) state_nxt = ST_DROP;
            ST_DROP:   if (!fin_s) state_nxt = ST_MOTION;
            ST_MOTION: if (motion_done_i) state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    // Counters reload whenever their condition is not running
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dly_r <= CODE_RST;
            acc_r <= CODE_RST;
        end else begin
            dly_r <= (state_r == ST_DELAY && !dly_done) ? dly_r - 32'h1 : 32'(STROBE_DELAY);
            acc_r <= (state_r == ST_STROBE && fin_s && !acc_done) ? acc_r - 32'h1 : 32'(ACCEPT_TIME);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r                 <= ST_IDLE;
            cmd_ready_o             <= 1'b0;
            block_done_o            <= 1'b0;
            alarm_o                 <= 1'b0;
            sel_r                   <= 5'h00;
            s_hold_r                <= CODE_RST;
            t_hold_r                <= CODE_RST;
            gear_hold_r             <= 4'h0;
            m_code_o                <= CODE_RST;
            m2_code_o               <= 16'h0000;
            m3_code_o               <= 16'h0000;
            s_code_o                <= CODE_RST;
            gear_o                  <= 4'h0;
            tool_data_o             <= CODE_RST;
            m_code_strobe_o         <= 1'b0;
            second_m_code_strobe_o  <= 1'b0;
            third_m_code_strobe_o   <= 1'b0;
            spindle_code_strobe_o   <= 1'b0;
            tool_code_strobe_o      <= 1'b0;
            distribution_end_flag_o <= 1'b0;
            spindle_speed_o         <= CODE_RST;
        end else begin
            state_r                 <= state_nxt;
            // Alarmed block is dropped, so ready stays high for the next one
            cmd_ready_o             <= (state_nxt == ST_IDLE);
            block_done_o            <= (state_r == ST_MOTION) && motion_done_i;
            distribution_end_flag_o <= motion_done_i && (state_r != ST_IDLE);
            if (take) begin
                alarm_o <= bad;
            end
            if (take && !bad) begin
                sel_r    <= {out_t, out_s, out_m3, out_m2, out_m1};
                s_hold_r <= s_word;
                t_hold_r <= cmd_i.t_val;
                if (cmd_i.s_valid) begin
                    spindle_speed_o <= s_v;
                end
                m_code_o  <= out_m1 ? cmd_i.m_val : CODE_RST;
                m2_code_o <= out_m2 ? cmd_i.m2_val : 16'h0000;
                m3_code_o <= out_m3 ? cmd_i.m3_val : 16'h0000;
                gear_hold_r <= (out_s && !io_spindle_mode_i) ? gear : 4'h0;
                tool_data_o <= out_t ? cmd_i.t_val : CODE_RST;
            end
            if (state_r == ST_DELAY && dly_done) begin
                m_code_strobe_o        <= sel_r[0];
                second_m_code_strobe_o <= sel_r[1];
                third_m_code_strobe_o  <= sel_r[2];
                spindle_code_strobe_o  <= sel_r[3];
                tool_code_strobe_o     <= sel_r[4];
                s_code_o               <= sel_r[3] ? s_hold_r : CODE_RST;
                // Gear bits are the spindle code in analog mode, so they rise with the strobe
                gear_o                 <= gear_hold_r;
            end
            if (state_r == ST_STROBE && acc_done) begin
                m_code_strobe_o        <= 1'b0;
                second_m_code_strobe_o <= 1'b0;
                third_m_code_strobe_o  <= 1'b0;
                spindle_code_strobe_o  <= 1'b0;
                tool_code_strobe_o     <= 1'b0;
            end
            if (state_r == ST_DROP && !fin_s) begin
                m_code_o    <= CODE_RST;
                m2_code_o   <= 16'h0000;
                m3_code_o   <= 16'h0000;
                s_code_o    <= CODE_RST;
                gear_o      <= 4'h0;
                tool_data_o <= CODE_RST;
            end
        end
    end

    wire logic any_strobe = m_code_strobe_o || second_m_code_strobe_o || third_m_code_strobe_o
                            || spindle_code_strobe_o || tool_code_strobe_o;
    logic lock_blk_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock_blk_r <= 1'b0;
        end else if (take) begin
            lock_blk_r <= lock_s;
        end
    end

    sequence seq_delay_end;
        (state_r == ST_DELAY) && dly_done;
    endsequence
    sequence seq_fin_accepted;
        (state_r == ST_STROBE) && acc_done;
    endsequence

    AST_STROBE_AFTER_DELAY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(m_code_strobe_o) |-> $past(state_r == ST_DELAY) && $past(dly_done))
        else $error("M strobe rose before delay expired");
    AST_CODE_HELD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        m_code_strobe_o && $past(m_code_strobe_o) |-> $stable(m_code_o))
        else $error("M code changed while strobe high");
    AST_DROP_ON_ACCEPT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        seq_fin_accepted |=> !any_strobe)
        else $error("Strobes not dropped after accepted completion");
    AST_NO_EARLY_DROP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $fell(any_strobe) |-> $past(fin_s) && $past(acc_r) == 32'h0)
        else $error("Strobe dropped without held completion");
    AST_CLEAR_CODES: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_r == ST_DROP) && !fin_s |=> (m_code_o == 32'h0) && (s_code_o == 32'h0) && (tool_data_o == 32'h0))
        else $error("Codes not cleared after completion low");
    AST_BLOCK_WAITS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        block_done_o |-> $past(motion_done_i) && $past(state_r == ST_MOTION))
        else $error("Block ended before motion done");
    AST_LOCK_EXEMPT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(m_code_strobe_o) && lock_blk_r |-> lock_exempt(m_code_o))
        else $error("Locked M code was strobed");
    AST_IO_ONE_BIT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(spindle_code_strobe_o) && io_spindle_mode_i |-> $onehot(s_code_o[7:0]) && s_code_o[31:8] == 24'h0)
        else $error("I/O spindle code not one bit");
    AST_S_WITH_STROBE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        seq_delay_end ##1 spindle_code_strobe_o |-> (s_code_o == s_hold_r) && (gear_o == gear_hold_r))
        else $error("Spindle code or gear not set with strobe");
    AST_ALARM_SILENT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        take && bad |=> !any_strobe && cmd_ready_o && (state_r == ST_IDLE))
        else $error("Alarmed block produced output");

endmodule : afs_handshake

// File: afs_pkg.sv
// Package for the auxiliary function strobe handshake block.
// Assumes one 100 MHz system clock shared by every user of the package.
package afs_pkg;

    // Clock and timing figures
    localparam int unsigned CLK_HZ             = 100_000_000;
    localparam int unsigned STROBE_DELAY_MS    = 64;
    localparam int unsigned STROBE_DELAY_CYC   = STROBE_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned ACCEPT_TIME_MS     = 10;
    localparam int unsigned ACCEPT_CYC         = ACCEPT_TIME_MS * (CLK_HZ / 1000);

    // Field widths and reset values
    localparam int unsigned M_W                = 32;
    localparam int unsigned MX_W               = 16;
    localparam logic [31:0] CODE_RST           = 32'h0000_0000;
    localparam logic [3:0]  DIGITS_RST         = 4'h8;

    // Codes exempt from the lock
    localparam logic [31:0] M_STOP             = 32'h0000_0000;
    localparam logic [31:0] M_OPT_STOP         = 32'h0000_0001;
    localparam logic [31:0] M_END              = 32'h0000_0002;
    localparam logic [31:0] M_END_RWD          = 32'h0000_001E;

    // Spindle I/O point range
    localparam logic [31:0] S_IO_MIN           = 32'h0000_0001;
    localparam logic [31:0] S_IO_MAX           = 32'h0000_0008;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_DELAY  = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_DROP   = 5'b01000,
        ST_MOTION = 5'b10000
    } afs_state_t;

    // One program block's auxiliary content
    typedef struct packed {
        logic [1:0]      m_cnt;
        logic [2:0]      m_internal;
        logic [M_W-1:0]  m_val;
        logic [MX_W-1:0] m2_val;
        logic [MX_W-1:0] m3_val;
        logic            s_valid;
        logic [31:0]     s_val;
        logic            t_valid;
        logic [31:0]     t_val;
    } afs_cmd_t;

    // Digit limits per function
    typedef struct packed {
        logic [3:0] m_digits;
        logic [3:0] s_digits;
        logic [3:0] t_digits;
    } afs_limits_t;

endpackage : afs_pkg

// File: afs_plc_model.sv
// Behavioural ladder-logic partner answering the strobes with the completion pin.
// Assumes strobes, codes and distribution end come from the handshake on clk_i.
`timescale 1ns/1ns
module afs_plc_model #(
    parameter int unsigned FIN_DELAY = 4
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Handshake pins
    input  wire logic [4:0]  strobes_i,
    input  wire logic [31:0] m_code_i,
    input  wire logic        distribution_end_flag_i,
    input  wire logic        wait_den_i,
    output logic             shared_completion_input_o,
    // Observation
    output logic [31:0]      seen_m_o,
    output logic [7:0]       accept_lat_o
);
    logic [7:0] wait_r;
    logic [4:0] prev_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shared_completion_input_o <= 1'b0;
            seen_m_o                  <= 32'h0000_0000;
            wait_r                    <= 8'h00;
            prev_r                    <= 5'h00;
            accept_lat_o              <= 8'h00;
        end else begin
            prev_r <= strobes_i;
            // Codes only trusted on the rising strobe
            if (strobes_i[0] && !prev_r[0]) seen_m_o <= m_code_i;
            if (shared_completion_input_o) accept_lat_o <= accept_lat_o + 8'h01;
            // Completion kept low while work is pending
            if (strobes_i != 5'h00 && !shared_completion_input_o) begin
                wait_r <= wait_r + 8'h01;
                if (wait_r >= FIN_DELAY[7:0] && (distribution_end_flag_i || !wait_den_i)) begin
                    shared_completion_input_o <= 1'b1;
                    accept_lat_o              <= 8'h00;
                end
            end else if (strobes_i == 5'h00 && shared_completion_input_o) begin
                shared_completion_input_o <= 1'b0;
                wait_r                    <= 8'h00;
            end
        end
    end
endmodule : afs_plc_model

// File: test_aux_function_strobe_handshake.sv
// Self-checking bench for the auxiliary code handshake with a behavioural PLC.
// Assumes afs_pkg, afs_handshake and afs_plc_model are compiled before it.
`timescale 1ns/1ns
module test_aux_function_strobe_handshake import afs_pkg::*; ;
    localparam int unsigned SD = 5;
    localparam int unsigned AT = 3;
    logic         clk_i, reset_n_i, cmd_valid_i, motion_done_i, cmd_ready_o, block_done_o, alarm_o;
    logic         multi_m, io_mode, auto_mode, lock, shared_completion_input, wait_den, distribution_end_flag;
    afs_cmd_t     cmd_i;
    afs_limits_t  limits_i;
    logic [127:0] gear_max_i;
    logic [31:0]  m_code, s_code, tool_data, spd, seen_m, rm, rs, rt;
    logic [15:0]  m2_code, m3_code;
    logic [3:0]   gear, rg;
    logic [4:0]   stb;
    logic [7:0]   lat;
    int           mismatches, tests_run, rn;

    afs_handshake #(.STROBE_DELAY(SD), .ACCEPT_TIME(AT)) dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .motion_done_i(motion_done_i), .cmd_ready_o(cmd_ready_o), .block_done_o(block_done_o),
        .alarm_o(alarm_o), .limits_i(limits_i), .multi_m_per_block_enable_i(multi_m),
        .io_spindle_mode_i(io_mode), .auto_mode_i(auto_mode), .gear_max_i(gear_max_i),
        .shared_completion_input_i(shared_completion_input), .aux_lock_input_i(lock), .m_code_o(m_code),
        .m2_code_o(m2_code), .m3_code_o(m3_code), .s_code_o(s_code), .gear_o(gear),
        .tool_data_o(tool_data), .m_code_strobe_o(stb[0]), .second_m_code_strobe_o(stb[1]),
        .third_m_code_strobe_o(stb[2]), .spindle_code_strobe_o(stb[3]), .tool_code_strobe_o(stb[4]),
        .distribution_end_flag_o(distribution_end_flag), .spindle_speed_o(spd));

    afs_plc_model #(.FIN_DELAY(4)) plc_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .strobes_i(stb), .m_code_i(m_code),
        .distribution_end_flag_i(distribution_end_flag), .wait_den_i(wait_den), .shared_completion_input_o(shared_completion_input),
        .seen_m_o(seen_m), .accept_lat_o(lat));

    always #5 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic afs_cmd_t mk(input logic [1:0] cnt, input logic [31:0] m, input logic sv,
                                    input logic [31:0] s, input logic tv, input logic [31:0] t);
        afs_cmd_t c;
        c = '0;
        c.m_cnt = cnt; c.m_val = m; c.s_valid = sv; c.s_val = s; c.t_valid = tv; c.t_val = t;
        return c;
    endfunction : mk

    // Called 1 ns after an edge; returns 1 ns after the take edge
    task automatic send(input afs_cmd_t c);
        int n;
        n = 0;
        cmd_i = c;
        cmd_valid_i = 1'b1;
        @(posedge clk_i);
        while (cmd_ready_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        #1;
        cmd_valid_i = 1'b0;
    endtask : send

    // Full block: strobe timing, codes at strobe, clearing after completion
    task automatic run(input afs_cmd_t c, input logic [4:0] exp);
        int first;
        logic [4:0] seen;
        logic done;
        first = 0; seen = 5'h00; done = 1'b0; rn = 0;
        send(c);
        while (!done && rn < 400) begin
            @(posedge clk_i);
            rn++;
            done = (block_done_o === 1'b1);
            if (stb != 5'h00 && seen == 5'h00) begin
                first = rn; rm = m_code; rs = s_code; rt = tool_data; rg = gear;
            end
            seen |= stb;
        end
        #1;
        chk({27'h0, seen}, {27'h0, exp}, "strobe set");
        chk({31'h0, done}, 32'h1, "block done");
        if (exp != 5'h00) chk({31'h0, first >= SD + 1 && first <= SD + 4}, 32'h1, "strobe delay");
        if (exp != 5'h00) chk({31'h0, lat >= AT + 3 && lat <= AT + 7}, 32'h1, "accept time");
        chk(m_code | s_code | tool_data | {m2_code, m3_code}, 32'h0, "codes cleared");
    endtask : run

    // Limit exceeded: alarm and no strobe at all
    task automatic expect_alarm(input afs_cmd_t c);
        send(c);
        @(posedge clk_i);
        #1;
        chk({31'h0, alarm_o}, 32'h1, "alarm");
        chk({31'h0, cmd_ready_o}, 32'h1, "ready after alarm");
        repeat (SD + 4) @(posedge clk_i);
        #1;
        chk({27'h0, stb}, 32'h0, "no strobe on alarm");
    endtask : expect_alarm

    task automatic t_single_m;
        run(mk(2'd1, 32'h05F5_E0FF, 1'b0, 0, 1'b0, 0), 5'h01);
        chk(rm, 32'h05F5_E0FF, "m code at strobe");
        chk(seen_m, 32'h05F5_E0FF, "m code seen by plc");
        $display("test single_m done");
    endtask : t_single_m

    task automatic t_mst;
        afs_cmd_t c;
        c = mk(2'd3, 32'h0000_0003, 1'b1, 32'd1500, 1'b1, 32'h0000_025B);
        c.m2_val = 16'h0005;
        c.m3_val = 16'h0008;
        for (int k = 0; k < 2; k++) begin
            multi_m = k[0];
            tick(2);
            send(c);
            chk({m2_code, m3_code}, k ? 32'h0005_0008 : 32'h0, "extra m groups");
            chk(tool_data, 32'h0000_025B, "tool data");
            chk({28'h0, gear}, 32'h0, "gear waits for strobe");
            tick(SD + 20);
        end
        run(c, 5'h1F);
        chk(rs, 32'd1500, "s code with strobe");
        chk({28'h0, rg}, 32'h2, "gear select");
        chk(rt, 32'h0000_025B, "t code with strobe");
        $display("test mst done");
    endtask : t_mst

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic t_limits;
        limits_i = '{m_digits: 4'h2, s_digits: 4'h8, t_digits: 4'h8};
        expect_alarm(mk(2'd1, 32'd100, 1'b0, 0, 1'b0, 0));
        run(mk(2'd1, 32'd99, 1'b0, 0, 1'b0, 0), 5'h01);
        limits_i = '{m_digits: 4'h8, s_digits: 4'h2, t_digits: 4'h2};
        expect_alarm(mk(2'd0, 0, 1'b1, 32'd100, 1'b0, 0));
        expect_alarm(mk(2'd0, 0, 1'b0, 0, 1'b1, 32'd100));
        limits_i = '{m_digits: 4'h8, s_digits: 4'h8, t_digits: 4'h8};
        io_mode = 1'b1;
        expect_alarm(mk(2'd0, 0, 1'b1, 32'd0, 1'b0, 0));
        expect_alarm(mk(2'd0, 0, 1'b1, 32'd9, 1'b0, 0));
        run(mk(2'd0, 0, 1'b1, 32'd8, 1'b0, 0), 5'h08);
        chk(rs, 32'h0000_0080, "io spindle bit");
        io_mode = 1'b0;
        $display("test limits done");
    endtask : t_limits

    task automatic t_lock_internal;
        afs_cmd_t c;
        c = mk(2'd1, 32'd98, 1'b0, 0, 1'b0, 0);
        c.m_internal = 3'b001;
        run(c, 5'h00);
        auto_mode = 1'b1;
        lock = 1'b1;
        tick(3);
        run(mk(2'd1, 32'd3, 1'b0, 0, 1'b0, 0), 5'h00);
        run(mk(2'd0, 0, 1'b1, 32'd700, 1'b0, 0), 5'h00);
        chk(spd, 32'd700, "speed under lock");
        run(mk(2'd1, 32'h0000_001E, 1'b0, 0, 1'b0, 0), 5'h01);
        auto_mode = 1'b0;
        tick(3);
        run(mk(2'd1, 32'd3, 1'b0, 0, 1'b0, 0), 5'h01);
        lock = 1'b0;
        $display("test lock_internal done");
    endtask : t_lock_internal

    task automatic t_motion;
        motion_done_i = 1'b0;
        wait_den = 1'b1;
        fork
            begin
                tick(40);
                motion_done_i = 1'b1;
            end
        join_none
        run(mk(2'd1, 32'd5, 1'b0, 0, 1'b0, 0), 5'h01);
        chk({31'h0, rn > 40}, 32'h1, "waits for motion");
        wait_den = 1'b0;
        $display("test motion done");
    endtask : t_motion

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial begin
        #60000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        clk_i = 1'b0; reset_n_i = 1'b0; cmd_valid_i = 1'b0; cmd_i = '0; motion_done_i = 1'b1;
        multi_m = 1'b1; io_mode = 1'b0; auto_mode = 1'b0; lock = 1'b0; wait_den = 1'b0;
        limits_i = '{m_digits: 4'h8, s_digits: 4'h8, t_digits: 4'h8};
        gear_max_i = {32'd4000, 32'd3000, 32'd2000, 32'd1000};
        mismatches = 0; tests_run = 0;
        tick(3);
        reset_n_i = 1'b1;
        tick(2);
        t_single_m();
        t_mst();
        t_limits();
        t_lock_internal();
        t_motion();
        tally_and_finish();
    end
endmodule : test_aux_function_strobe_handshake
